/* File: inc/tai_params.svh */
`ifndef TAI_PARAMS_SVH
`define TAI_PARAMS_SVH
// stream bytes
`define TAI_PRE_ZERO 8'h00
`define TAI_PRE_ONES 8'hFF
`define TAI_RAW_TAG 8'h60
`define TAI_FILL 8'h80
`define TAI_SDID_DUMMY 8'h80
`define TAI_WC_DUMMY 8'h80
`define TAI_SDID_TTX 8'h80
`define TAI_WC_TTX 8'h89
`define TAI_DID_FIXED 3'b010
// event codes, bits 1..0 of the data id code; bit 2 is the field
`define TAI_EV_START 2'b00
`define TAI_EV_VBI 2'b01
`define TAI_EV_END 2'b10
`define TAI_EV_FULL 2'b11
// byte positions within a packet
`define TAI_IDX_DID 6'd3
`define TAI_IDX_SDID 6'd4
`define TAI_IDX_WC 6'd5
`define TAI_IDX_LINE_LO 6'd6
`define TAI_IDX_LINE_HI 6'd7
`define TAI_IDX_PAY_FIRST 6'd8
`define TAI_IDX_PAY_LAST 6'd40
`define TAI_IDX_CKS 6'd41
`define TAI_LAST_DUMMY 6'd5
`define TAI_LAST_TTX 6'd43
`define TAI_LAST_RAW_PRE 6'd3
// line numbers
`define TAI_LINE_FIRST 9'd1
`define TAI_LINE_VBI_END 9'd23
// data id values of the dummy blocks
`define TAI_DID_START_F1 8'h50
`define TAI_DID_START_F2 8'h94
`define TAI_DID_END_F1 8'h92
`define TAI_DID_END_F2 8'h56
`endif

/* File: inc/tai_pkg.sv */
package tai_pkg;
   // one output byte with framing marks
   typedef struct packed {
      logic [7:0] data;
      logic sop;
      logic eop;
   } tai_byte_t;
   // blanking event from the line timing logic
   typedef struct packed {
      logic [8:0] line;
      logic field;
      logic ttx_avail;
      logic [4:0] int_id;
   } tai_line_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PKT = 2'b01,
      ST_RAW_PRE = 2'b10,
      ST_RAW = 2'b11
   } tai_state_t;
   typedef enum logic [1:0] {
      K_START = 2'b00,
      K_TTX = 2'b01,
      K_END = 2'b10
   } tai_kind_t;
endpackage

/* File: hw/tai_inserter.sv */
`timescale 1ns/1ps
`include "tai_params.svh"

module tai_buf2 #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // two entries so a drain stall never drops a word
   assign in_ready = (count != 2'd2);
   assign out_valid = (count != 2'd0);
   assign out_data = mem[rd_ptr];

   // pointers and occupancy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'd0;
      end else begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop) rd_ptr <= ~rd_ptr;
         count <= count + 2'(push) - 2'(pop);
      end
   end

   // storage needs no reset
   always_ff @(posedge clk) begin
      if (push) mem[wr_ptr] <= in_data;
   end
endmodule

module tai_inserter (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // mode controls
   input wire logic bt656_mode,
   input wire logic raw_enable,
   // line timing
   input wire logic blank_start,
   input wire tai_pkg::tai_line_t line_info,
   input wire logic sav_done,
   input wire logic vbi_line,
   // sliced teletext bytes, packet address 1 onward
   input wire logic ttx_valid,
   output logic ttx_ready,
   input wire logic [7:0] ttx_data,
   // raw converter samples at the 2x rate
   input wire logic raw_valid,
   input wire logic [7:0] raw_data,
   // luma byte stream toward the receiver
   output tai_pkg::tai_byte_t anc_out,
   output logic anc_valid,
   input wire logic anc_ready
);
   logic [1:0] rst_q;
   wire rst_n = rst_q[1];
   tai_pkg::tai_state_t state;
   tai_pkg::tai_kind_t kind;
   logic [5:0] idx;
   logic [5:0] sum;
   logic pend_start;
   logic pend_ttx;
   logic pend_end;
   logic pend_raw;
   tai_pkg::tai_line_t line_q;
   logic buf_valid;
   logic [7:0] buf_data;

   // reset released through two flops
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) rst_q <= 2'b00;
      else rst_q <= {rst_q[0], 1'b1};
   end

   // byte buffer in the teletext path
   wire buf_pop;
   tai_buf2 #(.W(8)) u_buf (
      .clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(ttx_valid),
      .in_ready(ttx_ready),
      .in_data(ttx_data),
      .out_valid(buf_valid),
      .out_ready(buf_pop),
      .out_data(buf_data)
   );

   // event code and data id byte
   wire ttx_full = line_q.line > `TAI_LINE_VBI_END;
   wire [1:0] ev = (kind == tai_pkg::K_START) ? `TAI_EV_START :
                   (kind == tai_pkg::K_END) ? `TAI_EV_END :
                   ttx_full ? `TAI_EV_FULL : `TAI_EV_VBI;
   wire [5:0] did_low = {`TAI_DID_FIXED, line_q.field, ev};
   wire did_par = ^did_low;
   wire [7:0] did = {~did_par, did_par, did_low};
   wire cks_par = ^sum;
   wire [7:0] cks = {~cks_par, cks_par, sum};

   // byte selection by position
   wire is_ttx = (kind == tai_pkg::K_TTX);
   wire in_pay = is_ttx && idx >= `TAI_IDX_PAY_FIRST && idx <= `TAI_IDX_PAY_LAST;
   wire [7:0] hdr_byte = (idx == 6'd0) ? `TAI_PRE_ZERO :
                         (idx < `TAI_IDX_DID) ? `TAI_PRE_ONES :
                         (idx == `TAI_IDX_DID) ? did :
                         (idx == `TAI_IDX_SDID) ? (is_ttx ? `TAI_SDID_TTX : `TAI_SDID_DUMMY) :
                         (is_ttx ? `TAI_WC_TTX : `TAI_WC_DUMMY);
   wire [7:0] ttx_byte = (idx == `TAI_IDX_LINE_LO) ? line_q.line[7:0] :
                         (idx == `TAI_IDX_LINE_HI) ? {2'b00, line_q.line[8], line_q.int_id} :
                         in_pay ? buf_data :
                         (idx == `TAI_IDX_CKS) ? cks : `TAI_FILL;
   wire [7:0] raw_pre = (idx == 6'd0) ? `TAI_PRE_ZERO :
                        (idx == `TAI_LAST_RAW_PRE) ? `TAI_RAW_TAG : `TAI_PRE_ONES;
   wire [7:0] sel_byte = (state == tai_pkg::ST_RAW) ? raw_data :
                         (state == tai_pkg::ST_RAW_PRE) ? raw_pre :
                         (idx <= `TAI_IDX_WC) ? hdr_byte : ttx_byte;
   wire [5:0] last_idx = (state == tai_pkg::ST_RAW_PRE) ? `TAI_LAST_RAW_PRE :
                         is_ttx ? `TAI_LAST_TTX : `TAI_LAST_DUMMY;

   // handshake: load the output register when it is free
   wire advance = !anc_valid || anc_ready;
   wire stall = (state == tai_pkg::ST_PKT && in_pay && !buf_valid) ||
                (state == tai_pkg::ST_RAW && !raw_valid);
   wire ld = advance && !stall && state != tai_pkg::ST_IDLE;
   wire last = (state != tai_pkg::ST_RAW) && idx == last_idx;
   assign buf_pop = ld && state == tai_pkg::ST_PKT && in_pay;
   wire raw_stop = state == tai_pkg::ST_RAW && !vbi_line;
   wire done_pkt = ld && last && state == tai_pkg::ST_PKT;

   // pending events; a new event wins over the clear of the old one
   wire set_start = blank_start && bt656_mode && line_info.line == `TAI_LINE_FIRST;
   wire set_ttx = blank_start && bt656_mode && line_info.ttx_avail;
   wire set_end = blank_start && bt656_mode && line_info.line == `TAI_LINE_VBI_END;
   wire set_raw = sav_done && vbi_line && raw_enable;
   wire clr_start = done_pkt && kind == tai_pkg::K_START;
   wire clr_ttx = done_pkt && kind == tai_pkg::K_TTX;
   wire clr_end = done_pkt && kind == tai_pkg::K_END;
   wire clr_raw = ld && last && state == tai_pkg::ST_RAW_PRE;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_start <= 1'b0;
         pend_ttx <= 1'b0;
         pend_end <= 1'b0;
         pend_raw <= 1'b0;
      end else begin
         pend_start <= set_start || (pend_start && !clr_start);
         pend_ttx <= set_ttx || (pend_ttx && !clr_ttx);
         pend_end <= set_end || (pend_end && !clr_end);
         pend_raw <= set_raw || (pend_raw && !clr_raw);
      end
   end

   // line context held for the whole blanking burst
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) line_q <= '0;
      else if (blank_start) line_q <= line_info;
   end

   // start dummy, then teletext, then end dummy, then raw
   tai_pkg::tai_state_t next_state;
   tai_pkg::tai_kind_t next_kind;
   always_comb begin
      next_state = state;
      next_kind = kind;
      case (state)
         tai_pkg::ST_IDLE: begin
            if (pend_start) begin
               next_state = tai_pkg::ST_PKT;
               next_kind = tai_pkg::K_START;
            end else if (pend_ttx) begin
               next_state = tai_pkg::ST_PKT;
               next_kind = tai_pkg::K_TTX;
            end else if (pend_end) begin
               next_state = tai_pkg::ST_PKT;
               next_kind = tai_pkg::K_END;
            end else if (pend_raw) begin
               next_state = tai_pkg::ST_RAW_PRE;
            end
         end
         tai_pkg::ST_PKT: begin
            if (done_pkt) next_state = tai_pkg::ST_IDLE;
         end
         tai_pkg::ST_RAW_PRE: begin
            if (ld && last) next_state = tai_pkg::ST_RAW;
         end
         tai_pkg::ST_RAW: begin
            if (raw_stop) next_state = tai_pkg::ST_IDLE;
         end
         default: next_state = tai_pkg::ST_IDLE;
      endcase
   end

   // state, position and running checksum
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= tai_pkg::ST_IDLE;
         kind <= tai_pkg::K_START;
         idx <= 6'd0;
         sum <= 6'd0;
      end else begin
         state <= next_state;
         kind <= next_kind;
         if (state == tai_pkg::ST_IDLE || (ld && last)) idx <= 6'd0;
         else if (ld && state != tai_pkg::ST_RAW) idx <= idx + 6'd1;
         if (state == tai_pkg::ST_IDLE) sum <= 6'd0;
         else if (ld && idx >= `TAI_IDX_LINE_LO && idx <= `TAI_IDX_PAY_LAST) sum <= sum + sel_byte[5:0];
      end
   end

   // output register; a raw burst has no end mark
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         anc_out <= '0;
         anc_valid <= 1'b0;
      end else if (advance) begin
         anc_valid <= ld;
         anc_out.data <= ld ? sel_byte : anc_out.data;
         anc_out.sop <= ld && idx == 6'd0 && state != tai_pkg::ST_RAW;
         anc_out.eop <= ld && last && state == tai_pkg::ST_PKT;
      end
   end

   // checks on the emitted stream
   sequence s_pkt_at(logic [5:0] p);
      ld && state == tai_pkg::ST_PKT && idx == p;
   endsequence
   chk_pre_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_pkt_at(6'd0) |=> anc_valid && anc_out.data == `TAI_PRE_ZERO && anc_out.sop)
      else $error("preamble first byte wrong");
   chk_pre_ones: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_pkt_at(6'd1) ##0 1'b1 |=> anc_out.data == `TAI_PRE_ONES)
      else $error("preamble ones byte wrong");
   chk_did_parity: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_pkt_at(`TAI_IDX_DID) |=> anc_out.data[7] != anc_out.data[6] &&
         anc_out.data[6] == ^anc_out.data[5:0] && anc_out.data[5:3] == `TAI_DID_FIXED)
      else $error("data id parity or pattern wrong");
   chk_start_did: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_pkt_at(`TAI_IDX_DID) ##0 kind == tai_pkg::K_START |=>
         anc_out.data == ($past(line_q.field) ? `TAI_DID_START_F2 : `TAI_DID_START_F1))
      else $error("field start data id wrong");
   chk_end_did: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_pkt_at(`TAI_IDX_DID) ##0 kind == tai_pkg::K_END |=>
         anc_out.data == ($past(line_q.field) ? `TAI_DID_END_F2 : `TAI_DID_END_F1))
      else $error("vbi end data id wrong");
   chk_dummy_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_pkt_at(`TAI_LAST_DUMMY) ##0 !is_ttx |=> anc_out.eop && anc_out.data == `TAI_WC_DUMMY &&
         state == tai_pkg::ST_IDLE)
      else $error("dummy packet length wrong");
   chk_ttx_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_pkt_at(`TAI_LAST_TTX) ##0 is_ttx |=> anc_out.eop && anc_out.data == `TAI_FILL)
      else $error("teletext packet length wrong");
   chk_cks_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_pkt_at(`TAI_IDX_CKS) ##0 is_ttx |=> anc_out.data[5:0] == $past(sum) &&
         anc_out.data[6] == ^anc_out.data[5:0])
      else $error("checksum byte wrong");
   chk_end_after_ttx: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state == tai_pkg::ST_IDLE && pend_ttx && pend_end && !pend_start |=> kind == tai_pkg::K_TTX)
      else $error("end dummy overtook teletext");
   chk_raw_tag: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ld && state == tai_pkg::ST_RAW_PRE && last |=> anc_out.data == `TAI_RAW_TAG ##0
         state == tai_pkg::ST_RAW)
      else $error("raw preamble tag wrong");
endmodule

/* File: bench/tai_rx_model.sv */
`timescale 1ns/1ps

module tai_rx_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // luma byte stream from the inserter
   input wire tai_pkg::tai_byte_t anc_out,
   input wire logic anc_valid,
   output logic anc_ready,
   // bench side
   input wire logic stall,
   output logic took,
   output tai_pkg::tai_byte_t took_byte,
   output logic did_bad
);
   logic [1:0] phase;
   logic [5:0] idx;

   // every accepted byte is handed to the bench
   assign took = anc_valid && anc_ready;
   assign took_byte = anc_out;

   // slow mode accepts one cycle in three to exercise the output hold
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase <= 2'd0;
         anc_ready <= 1'b0;
         idx <= 6'd0;
         did_bad <= 1'b0;
      end else begin
         phase <= (phase == 2'd2) ? 2'd0 : phase + 2'd1;
         anc_ready <= !stall || (phase == 2'd1);
         did_bad <= 1'b0;
         if (took) begin
            idx <= anc_out.sop ? 6'd1 : idx + 6'd1;
            // a packet opens on the zero byte; data id parity bits 7 and 6 must differ, bit 6 the parity of bits 5..0
            if (anc_out.sop && anc_out.data !== 8'h00) begin
               did_bad <= 1'b1;
            end
            if (!anc_out.sop && idx == 6'd3) begin
               did_bad <= (anc_out.data[6] !== ^anc_out.data[5:0]) || (anc_out.data[7] === anc_out.data[6]);
            end
         end
      end
   end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps

module tb;
   logic sys_clk, arst_n, bt656_mode, raw_enable, blank_start, sav_done, vbi_line;
   logic ttx_valid, ttx_ready, raw_valid, anc_valid, anc_ready, stall, took, did_bad, ttx_took;
   logic [7:0] ttx_data, raw_data;
   tai_pkg::tai_line_t line_info;
   tai_pkg::tai_byte_t anc_out, took_byte;
   tai_pkg::tai_byte_t got[$];
   logic [7:0] feed[$];
   logic [7:0] want[$];
   // expected sop and eop marks, one pair per wanted byte
   logic [1:0] mk[$];
   int num_errors, comparisons;

   // 100 ns period
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   tai_inserter i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .bt656_mode(bt656_mode), .raw_enable(raw_enable),
      .blank_start(blank_start), .line_info(line_info), .sav_done(sav_done), .vbi_line(vbi_line),
      .ttx_valid(ttx_valid), .ttx_ready(ttx_ready), .ttx_data(ttx_data), .raw_valid(raw_valid),
      .raw_data(raw_data), .anc_out(anc_out), .anc_valid(anc_valid), .anc_ready(anc_ready));

   tai_rx_model i_rx (.sys_clk(sys_clk), .arst_n(arst_n), .anc_out(anc_out), .anc_valid(anc_valid),
      .anc_ready(anc_ready), .stall(stall), .took(took), .took_byte(took_byte), .did_bad(did_bad));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // collect accepted bytes; note slicer handshakes for the feeder
   always @(posedge sys_clk) begin
      ttx_took <= ttx_valid && ttx_ready;
      if (took) got.push_back(took_byte);
      if (did_bad) check(8'h01, 8'h00);
   end

   // slicer feeder pops only after a taken edge, holds data otherwise
   always @(negedge sys_clk) begin
      if (ttx_took) void'(feed.pop_front());
      ttx_valid <= feed.size() > 0;
      ttx_data <= (feed.size() > 0) ? feed[0] : 8'h00;
   end

   function automatic logic [7:0] with_par(input logic [5:0] v);
      with_par = {~(^v), ^v, v};
   endfunction

   task automatic put_bytes(input logic [63:0] v, input int n, input logic s, input logic e);
      for (int i = n - 1; i >= 0; i--) begin
         want.push_back(v[i*8 +: 8]);
         mk.push_back({s && i == n - 1, e && i == 0});
      end
   endtask

   // one blank interval: start dummy, teletext, end dummy, each only if its id is non-zero
   task automatic run_line(input logic field, input logic [8:0] line, input logic [4:0] id,
                           input logic [7:0] start_id, input logic [7:0] ttx_id, input logic [7:0] end_id);
      logic [7:0] b[$];
      logic [7:0] sum;
      int n;
      got.delete();
      want.delete();
      mk.delete();
      if (start_id != 8'h00) put_bytes({24'h00_ffff, start_id, 8'h80, 8'h80}, 6, 1'b1, 1'b1);
      if (ttx_id != 8'h00) begin
         put_bytes({24'h00_ffff, ttx_id, 8'h80, 8'h89}, 6, 1'b1, 1'b0);
         b.push_back(line[7:0]);
         b.push_back({2'b00, line[8], id});
         for (int i = 0; i < 33; i++) begin
            b.push_back(8'h30 + line[7:0] + 8'(i));
            feed.push_back(8'h30 + line[7:0] + 8'(i));
         end
         sum = 8'h00;
         foreach (b[i]) sum += b[i];
         foreach (b[i]) begin
            want.push_back(b[i]);
            mk.push_back(2'b00);
         end
         put_bytes({with_par(sum[5:0]), 8'h80, 8'h80}, 3, 1'b0, 1'b1);
      end
      if (end_id != 8'h00) put_bytes({24'h00_ffff, end_id, 8'h80, 8'h80}, 6, 1'b1, 1'b1);
      line_info = '{line, field, (ttx_id != 8'h00), id};
      blank_start = 1'b1;
      @(negedge sys_clk);
      blank_start = 1'b0;
      n = 0;
      while (got.size() < want.size() && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      repeat (20) @(negedge sys_clk);
      check(8'(got.size()), 8'(want.size()));
      foreach (want[i]) if (i < got.size()) check(got[i].data, want[i]);
      foreach (mk[i]) if (i < got.size()) check({6'h00, got[i].sop, got[i].eop}, {6'h00, mk[i]});
      if (got.size() > 0) check({7'h00, got[got.size()-1].eop}, 8'h01);
   endtask

   task automatic field_one();
      run_line(1'b0, 9'd1, 5'h03, 8'h50, 8'h91, 8'h00);
      run_line(1'b0, 9'd23, 5'h11, 8'h00, 8'h91, 8'h92);
      stall = 1'b1;
      run_line(1'b0, 9'd24, 5'h1f, 8'h00, 8'h53, 8'h00);
      stall = 1'b0;
      run_line(1'b0, 9'd262, 5'h00, 8'h00, 8'h53, 8'h00);
   endtask

   task automatic field_two();
      run_line(1'b1, 9'd1, 5'h02, 8'h94, 8'h00, 8'h00);
      run_line(1'b1, 9'd23, 5'h15, 8'h00, 8'h55, 8'h56);
      run_line(1'b1, 9'd300, 5'h0a, 8'h00, 8'h97, 8'h00);
   endtask

   task automatic mode_off();
      bt656_mode = 1'b0;
      run_line(1'b0, 9'd1, 5'h01, 8'h00, 8'h00, 8'h00);
      bt656_mode = 1'b1;
   endtask

   // raw burst: preamble after sav, then samples on back-to-back 2x cycles
   task automatic raw_out();
      int n;
      got.delete();
      // with raw output off a sav on a vbi line stays silent
      vbi_line = 1'b1;
      sav_done = 1'b1;
      @(negedge sys_clk);
      sav_done = 1'b0;
      repeat (10) @(negedge sys_clk);
      check(8'(got.size()), 8'h00);
      raw_enable = 1'b1;
      sav_done = 1'b1;
      @(negedge sys_clk);
      sav_done = 1'b0;
      n = 0;
      while (got.size() < 4 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      for (int i = 0; i < 4; i++) begin
         raw_valid = 1'b1;
         raw_data = 8'ha0 + 8'(i);
         @(negedge sys_clk);
      end
      raw_valid = 1'b0;
      vbi_line = 1'b0;
      raw_enable = 1'b0;
      repeat (10) @(negedge sys_clk);
      want.delete();
      mk.delete();
      put_bytes(64'h00ff_ff60_a0a1_a2a3, 8, 1'b1, 1'b0);
      check(8'(got.size()), 8'h08);
      foreach (want[i]) if (i < got.size()) check(got[i].data, want[i]);
      foreach (mk[i]) if (i < got.size()) check({6'h00, got[i].sop, got[i].eop}, {6'h00, mk[i]});
   endtask

   // cut a hang short well past the expected run
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      report_and_stop();
   end

   initial begin
      arst_n = 1'b0;
      bt656_mode = 1'b1;
      raw_enable = 1'b0;
      blank_start = 1'b0;
      sav_done = 1'b0;
      vbi_line = 1'b0;
      raw_valid = 1'b0;
      raw_data = 8'h00;
      stall = 1'b0;
      line_info = '0;
      num_errors = 0;
      comparisons = 0;
      repeat (5) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      field_one();
      field_two();
      mode_off();
      raw_out();
      report_and_stop();
   end
endmodule
